// *** logic/tdf_top.v ***
// decision logic of a burst-mode capacitive touch sensor
`timescale 1ns/1ps
`include "tdf_consts.vh"

module tdf_top #(
  parameter [14:0] HB_CYCLES    = `TDF_HB_CYCLES,
  parameter [16:0] MS_CYCLES    = `TDF_MS_CYCLES,
  parameter [15:0] TO_SHORT_MS  = `TDF_TO_SHORT_MS,
  parameter [15:0] TO_LONG_MS   = `TDF_TO_LONG_MS
) (
  input  wire        clock,
  input  wire        resetn,
  input  wire        sample_valid,
  input  wire [15:0] sample,
  input  wire        gain_strap,
  input  wire        output_option_strap_a,
  input  wire        output_option_strap_b,
  output reg         out_o,
  output reg         out_oe_n,
  output reg         detect_active,
  output reg         calibrating
);

  // ************************************************************
  // states
  // ************************************************************
  localparam [1:0] ST_STRAP = 2'h0;
  localparam [1:0] ST_CAL   = 2'h1;
  localparam [1:0] ST_RUN   = 2'h2;

  // ************************************************************
  // functions
  // ************************************************************
  // saturating add keeps the threshold from wrapping near full scale
  function [15:0] tdf_sat_add;
    input [15:0] a;
    input [15:0] b;
    reg   [16:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      tdf_sat_add = s[16] ? `TDF_ONES : s[15:0];
    end
  endfunction

  function [15:0] tdf_hyst;
    input [15:0] delta;
    reg   [31:0] p;
    begin
      p = ({16'h0000, delta} * `TDF_HYST_PCT) / `TDF_PCT_FULL;
      tdf_hyst = p[15:0];
    end
  endfunction

  // ************************************************************
  // strap synchronisers and power-up capture
  // ************************************************************
  reg  [2:0]  strap_meta;
  reg  [2:0]  strap_sync;
  reg  [1:0]  settle_cnt;
  reg         gain_high;
  reg  [1:0]  opt_mode;
  reg  [1:0]  state;

  always @(posedge clock) begin
    if (!resetn) begin
      strap_meta <= 3'h0;
      strap_sync <= 3'h0;
    end else begin
      strap_meta <= {gain_strap, output_option_strap_a, output_option_strap_b};
      strap_sync <= strap_meta;
    end
  end

  // captured once after release; later strap changes are not seen
  always @(posedge clock) begin
    if (!resetn) begin
      settle_cnt <= 2'h0;
      gain_high  <= 1'b0;
      opt_mode   <= `TDF_OPT_TOGGLE;
    end else if (state == ST_STRAP) begin
      if (settle_cnt == `TDF_STRAP_SETTLE) begin
        gain_high <= strap_sync[2];
        opt_mode  <= strap_sync[1:0];
      end else begin
        settle_cnt <= settle_cnt + 2'h1;
      end
    end
  end

  // ************************************************************
  // mode decode
  // ************************************************************
  reg         toggle_mode;
  reg  [15:0] timeout_ms;
  reg         timeout_finite;
  wire [15:0] thr_delta;

  always @* begin
    toggle_mode    = 1'b0;
    timeout_ms     = TO_SHORT_MS;
    timeout_finite = 1'b1;
    case (opt_mode)
      `TDF_OPT_LVL_SHORT: begin
        timeout_ms = TO_SHORT_MS;
      end
      `TDF_OPT_LVL_LONG: begin
        timeout_ms = TO_LONG_MS;
      end
      `TDF_OPT_TOGGLE: begin
        toggle_mode = 1'b1;
        timeout_ms  = TO_SHORT_MS;
      end
      `TDF_OPT_LVL_INF: begin
        timeout_finite = 1'b0;
      end
      default: begin
        timeout_ms = TO_SHORT_MS;
      end
    endcase
  end

  assign thr_delta = gain_high ? `TDF_THR_HIGH_GAIN : `TDF_THR_LOW_GAIN;

  // ************************************************************
  // reference and levels
  // ************************************************************
  wire [15:0] reference;
  wire [15:0] thr_level;
  wire [15:0] rel_level;
  wire        ref_load;
  wire        ref_step;
  wire        above_thr;
  wire        below_rel;

  assign ref_load = sample_valid && (state == ST_CAL);
  assign ref_step = sample_valid && (state == ST_RUN) && !detect_active;

  tdf_ref_track u_ref (
    .clock     (clock),
    .resetn    (resetn),
    .load      (ref_load),
    .step_en   (ref_step),
    .sample    (sample),
    .reference (reference)
  );

  // levels slave to the reference so drift moves them together
  assign thr_level = tdf_sat_add(reference, thr_delta);
  assign rel_level = thr_level - tdf_hyst(thr_delta);
  assign above_thr = (sample > thr_level);
  assign below_rel = (sample < rel_level);

  // ************************************************************
  // millisecond prescaler and detection timer
  // ************************************************************
  // a prescaler keeps the timer narrow; 60 s of raw cycles needs 33 bits
  reg  [16:0] ms_pre;
  reg  [15:0] on_ms;
  wire        ms_tick;
  wire        timed_out;

  assign ms_tick   = (ms_pre == MS_CYCLES - 17'h00001);
  assign timed_out = detect_active && timeout_finite && (on_ms >= timeout_ms);

  always @(posedge clock) begin
    if (!resetn) begin
      ms_pre <= 17'h00000;
      on_ms  <= 16'h0000;
    end else if (!detect_active) begin
      ms_pre <= 17'h00000;
      on_ms  <= 16'h0000;
    end else if (ms_tick) begin
      ms_pre <= 17'h00000;
      if (on_ms != 16'hFFFF) begin
        on_ms <= on_ms + 16'h0001;
      end
    end else begin
      ms_pre <= ms_pre + 17'h00001;
    end
  end

  // ************************************************************
  // detection integrator and state machine
  // ************************************************************
  reg  [1:0]  integ;
  reg         toggle_q;

  always @(posedge clock) begin
    if (!resetn) begin
      state         <= ST_STRAP;
      integ         <= `TDF_INTEG_RESET;
      detect_active <= 1'b0;
      toggle_q      <= 1'b0;
      calibrating   <= 1'b1;
    end else begin
      case (state)
        ST_STRAP: begin
          if (settle_cnt == `TDF_STRAP_SETTLE) begin
            state <= ST_CAL;
          end
        end
        ST_CAL: begin
          integ         <= `TDF_INTEG_RESET;
          detect_active <= 1'b0;
          if (sample_valid) begin
            state       <= ST_RUN;
            calibrating <= 1'b0;
          end
        end
        ST_RUN: begin
          if (timed_out) begin
            // toggle state survives; level output follows detect_active
            state         <= ST_CAL;
            calibrating   <= 1'b1;
            detect_active <= 1'b0;
            integ         <= `TDF_INTEG_RESET;
          end else if (sample_valid) begin
            if (detect_active) begin
              if (below_rel) begin
                detect_active <= 1'b0;
              end
            end else if (above_thr) begin
              if (integ == `TDF_INTEG_LAST) begin
                detect_active <= 1'b1;
                integ         <= `TDF_INTEG_RESET;
                if (toggle_mode) begin
                  toggle_q <= !toggle_q;
                end
              end else begin
                integ <= integ + 2'h1;
              end
            end else begin
              integ <= `TDF_INTEG_RESET;
            end
          end
        end
        default: begin
          state <= ST_STRAP;
        end
      endcase
    end
  end

  // ************************************************************
  // health pulse timer
  // ************************************************************
  reg  [14:0] hb_cnt;
  wire        hb_busy;

  assign hb_busy = (hb_cnt != 15'h0000);

  always @(posedge clock) begin
    if (!resetn) begin
      hb_cnt <= 15'h0000;
    end else if (sample_valid) begin
      hb_cnt <= HB_CYCLES;
    end else if (hb_busy) begin
      hb_cnt <= hb_cnt - 15'h0001;
    end
  end

  // ************************************************************
  // open-drain output
  // ************************************************************
  // the pin only ever sinks; a released pin shows the external pull
  wire        drive_low;

  assign drive_low = toggle_mode ? toggle_q : detect_active;

  always @(posedge clock) begin
    if (!resetn) begin
      out_o    <= 1'b0;
      out_oe_n <= 1'b1;
    end else begin
      out_o    <= 1'b0;
      out_oe_n <= hb_busy || !drive_low;
    end
  end

endmodule // tdf_top

// *** shared/tdf_consts.vh ***
// constants shared by the touch detect filter design files
`ifndef TDF_CONSTS_VH
`define TDF_CONSTS_VH

// datapath
`define TDF_WIDTH           16
`define TDF_ZERO            16'h0000
`define TDF_ONES            16'hFFFF

// clock rate and timing, each time in its own unit
`define TDF_CLK_MHZ         100
`define TDF_HB_US           300
// sized to the counters that load them: 300 us and 1 ms at 100 MHz
`define TDF_HB_CYCLES       15'h7530
`define TDF_MS_CYCLES       17'h186A0
`define TDF_TO_SHORT_S      10
`define TDF_TO_LONG_S       60
// timeouts in milliseconds: 10 s and 60 s
`define TDF_TO_SHORT_MS     16'h2710
`define TDF_TO_LONG_MS      16'hEA60

// detection thresholds above the reference, by gain strap
`define TDF_THR_HIGH_GAIN   16'h0006
`define TDF_THR_LOW_GAIN    16'h000C

// hysteresis as percent of threshold delta
`define TDF_HYST_PCT        32'h00000011
`define TDF_PCT_FULL        32'h00000064

// consecutive detections needed, counted from zero
`define TDF_INTEG_LAST      2'h2
`define TDF_INTEG_RESET     2'h0

// drift tracking: samples per one-count step of the reference
`define TDF_NEG_DIV         4'h2
`define TDF_POS_DIV         4'hF
`define TDF_DIV_RESET       4'h0

// output option decode, index is {strap_a, strap_b}
`define TDF_OPT_LVL_SHORT   2'h3
`define TDF_OPT_LVL_LONG    2'h2
`define TDF_OPT_TOGGLE      2'h0
`define TDF_OPT_LVL_INF     2'h1

// cycles after reset release before the straps are caught
`define TDF_STRAP_SETTLE    2'h3

`endif

// *** logic/tdf_ref_track.v ***
// slew-limited asymmetric reference tracker for the touch detect filter
`timescale 1ns/1ps
`include "tdf_consts.vh"

module tdf_ref_track (
  input  wire        clock,
  input  wire        resetn,
  input  wire        load,
  input  wire        step_en,
  input  wire [15:0] sample,
  output reg  [15:0] reference
);

  // ************************************************************
  // drift step dividers
  // ************************************************************
  reg  [3:0]  neg_cnt;
  reg  [3:0]  pos_cnt;
  wire        below;
  wire        above;

  assign below = (sample < reference);
  assign above = (sample > reference);

  // ************************************************************
  // reference update
  // ************************************************************
  // a rising signal is followed slowly so an approaching finger is not
  // absorbed; a falling one quickly so a removed obstruction recovers
  always @(posedge clock) begin
    if (!resetn) begin
      reference <= `TDF_ZERO;
      neg_cnt   <= `TDF_DIV_RESET;
      pos_cnt   <= `TDF_DIV_RESET;
    end else if (load) begin
      reference <= sample;
      neg_cnt   <= `TDF_DIV_RESET;
      pos_cnt   <= `TDF_DIV_RESET;
    end else if (step_en) begin
      if (below) begin
        pos_cnt <= `TDF_DIV_RESET;
        if (neg_cnt == `TDF_NEG_DIV - 4'h1) begin
          neg_cnt   <= `TDF_DIV_RESET;
          reference <= reference - 16'h0001;
        end else begin
          neg_cnt <= neg_cnt + 4'h1;
        end
      end else if (above) begin
        neg_cnt <= `TDF_DIV_RESET;
        if (pos_cnt == `TDF_POS_DIV - 4'h1) begin
          pos_cnt   <= `TDF_DIV_RESET;
          reference <= reference + 16'h0001;
        end else begin
          pos_cnt <= pos_cnt + 4'h1;
        end
      end else begin
        neg_cnt <= `TDF_DIV_RESET;
        pos_cnt <= `TDF_DIV_RESET;
      end
    end
  end

endmodule // tdf_ref_track

// *** tb/tdf_top_props.sv ***
// assertion checker for the touch detect filter top ports
`timescale 1ns/1ps
module tdf_top_props (
  input wire        clock,
  input wire        resetn,
  input wire        sample_valid,
  input wire [15:0] sample,
  input wire        gain_strap,
  input wire        output_option_strap_a,
  input wire        output_option_strap_b,
  input wire        out_o,
  input wire        out_oe_n,
  input wire        detect_active,
  input wire        calibrating
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // ****************************************
  // pin behaviour
  // ****************************************
  a_sink_only: assert property (out_o == 1'b0)
    else $error("pin drive value not low");
  a_reset_state: assert property (disable iff (1'b0)
    !resetn |=> out_oe_n && !detect_active && calibrating) else $error("bad reset state");
  // short check only: the full window is longer than a repetition may reach
  a_health_pulse: assert property (sample_valid |-> ##2 out_oe_n [*8])
    else $error("pin not released after burst");
  a_level_drive: assert property ((output_option_strap_a || output_option_strap_b)
    && !out_oe_n |-> $past(detect_active)) else $error("level pin low without detection");
  a_oe_release: assert property ($rose(out_oe_n)
    |-> $past(sample_valid, 2) || $past(detect_active, 2)) else $error("pin released idle");
  // ****************************************
  // decision timing
  // ****************************************
  a_detect_rise: assert property ($rose(detect_active)
    |-> $past(sample_valid) && !$past(calibrating)) else $error("detection without burst");
  a_detect_fall: assert property ($fell(detect_active)
    |-> $past(sample_valid) || calibrating) else $error("release without cause");
  a_cal_no_det: assert property (calibrating |-> !detect_active)
    else $error("detecting while calibrating");
  a_cal_end: assert property ($fell(calibrating) |-> $past(sample_valid))
    else $error("calibration ended without burst");
endmodule // tdf_top_props

bind tdf_top tdf_top_props u_props (
  .clock                 (clock),
  .resetn                (resetn),
  .sample_valid          (sample_valid),
  .sample                (sample),
  .gain_strap            (gain_strap),
  .output_option_strap_a (output_option_strap_a),
  .output_option_strap_b (output_option_strap_b),
  .out_o                 (out_o),
  .out_oe_n              (out_oe_n),
  .detect_active         (detect_active),
  .calibrating           (calibrating)
);

// *** tb/tdf_sense_model.sv ***
// front end and pull-up load model facing the touch detect filter
`timescale 1ns/1ps
module tdf_sense_model (
  input  wire        clock,
  output reg         sample_valid,
  output reg  [15:0] sample,
  input  wire        out_o,
  input  wire        out_oe_n,
  output wire        pin
);
  initial begin
    sample_valid = 1'b0;
    sample = 16'h5A5A;
  end
  // pull-up load: a released pin reads high
  assign pin = out_oe_n ? 1'b1 : out_o;
  // one word per burst; outside it the bus shows the inverse word
  task burst(input [15:0] v);
    begin
      sample_valid = 1'b1;
      sample = v;
      @(posedge clock);
      #1;
      sample_valid = 1'b0;
      sample = ~v;
      @(posedge clock);
      #1;
    end
  endtask
endmodule // tdf_sense_model

// *** tb/tb_top.sv ***
// self-checking testbench for the touch detect filter
`timescale 1ns/1ps
module tb_top;
  reg     clock = 1'b0;
  reg     resetn = 1'b0;
  reg     gain_strap = 1'b1;
  reg     output_option_strap_a = 1'b1;
  reg     output_option_strap_b = 1'b1;
  wire    sample_valid;
  wire    out_o;
  wire    out_oe_n;
  wire    detect_active;
  wire    calibrating;
  wire    pin;
  wire [15:0] sample;
  integer bad_count = 0;
  integer n_tests = 0;
  // short timing: health 20 cycles, 1 ms = 10 cycles, timeouts 40 and 80 cycles
  tdf_top #(.HB_CYCLES(15'h0014), .MS_CYCLES(17'h0000A), .TO_SHORT_MS(16'h0004),
    .TO_LONG_MS(16'h0008)) dut (
    .clock                 (clock),
    .resetn                (resetn),
    .sample_valid          (sample_valid),
    .sample                (sample),
    .gain_strap            (gain_strap),
    .output_option_strap_a (output_option_strap_a),
    .output_option_strap_b (output_option_strap_b),
    .out_o                 (out_o),
    .out_oe_n              (out_oe_n),
    .detect_active         (detect_active),
    .calibrating           (calibrating)
  );
  tdf_sense_model fe (
    .clock        (clock),
    .sample_valid (sample_valid),
    .sample       (sample),
    .out_o        (out_o),
    .out_oe_n     (out_oe_n),
    .pin          (pin)
  );
  initial forever #5 clock = ~clock;
  // ****************************************
  // helpers
  // ****************************************
  task check(input logic got, input logic exp, input string what);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("ERROR at %0t: %s", $time, what);
      end
    end
  endtask
  task wait_cyc(input integer n);
    begin
      repeat (n) @(posedge clock);
      #1;
    end
  endtask
  task hit(input [15:0] v, input integer n);
    repeat (n) fe.burst(v);
  endtask
  task start(input a, input b, input g, input [15:0] r);
    begin
      resetn = 1'b0;
      output_option_strap_a = a;
      output_option_strap_b = b;
      gain_strap = g;
      wait_cyc(2);
      resetn = 1'b1;
      wait_cyc(1);
      check(calibrating, 1'b1, "no calibration after reset");
      check(pin, 1'b1, "pin not released after reset");
      wait_cyc(8);
      fe.burst(r);
      check(calibrating, 1'b0, "calibration not ended");
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_integ;
    begin
      start(1'b1, 1'b1, 1'b1, 16'h0064);
      gain_strap = 1'b0;
      hit(16'h006B, 2);
      hit(16'h006A, 1);
      check(detect_active, 1'b0, "threshold not strict");
      hit(16'h006B, 2);
      check(detect_active, 1'b0, "integrator not cleared");
      hit(16'h006B, 1);
      check(detect_active, 1'b1, "no detection after three");
      wait_cyc(25);
      check(pin, 1'b0, "pin not driven while detecting");
      hit(16'h0069, 1);
      check(pin, 1'b1, "no health release");
      check(detect_active, 1'b1, "released inside hysteresis");
      hit(16'h0068, 1);
      check(detect_active, 1'b0, "not released below hysteresis");
      $display("t_integ done");
    end
  endtask
  task t_gain_low;
    begin
      start(1'b1, 1'b1, 1'b0, 16'h0064);
      hit(16'h0070, 3);
      check(detect_active, 1'b0, "low gain threshold wrong");
      hit(16'h0071, 3);
      check(detect_active, 1'b1, "low gain no detection");
      hit(16'h006E, 1);
      check(detect_active, 1'b1, "low gain early release");
      hit(16'h006D, 1);
      check(detect_active, 1'b0, "low gain no release");
      $display("t_gain_low done");
    end
  endtask
  task t_timeout(input a, input b, input integer lim);
    begin
      start(a, b, 1'b1, 16'h0064);
      hit(16'h006B, 3);
      if (lim == 0) begin
        wait_cyc(300);
        check(detect_active, 1'b1, "infinite mode timed out");
      end else begin
        wait_cyc(lim - 12);
        check(detect_active, 1'b1, "timeout too early");
        wait_cyc(24);
        check(detect_active, 1'b0, "no timeout");
        check(calibrating, 1'b1, "no recalibration");
        check(pin, 1'b1, "pin not released on timeout");
        fe.burst(16'h0064);
        hit(16'h006B, 3);
        check(detect_active, 1'b1, "no sensing after recal");
      end
      $display("t_timeout done");
    end
  endtask
  task t_toggle;
    begin
      start(1'b0, 1'b0, 1'b1, 16'h0064);
      hit(16'h006B, 3);
      wait_cyc(25);
      check(pin, 1'b0, "toggle not on");
      hit(16'h0064, 1);
      wait_cyc(25);
      check(pin, 1'b0, "toggle lost on release");
      hit(16'h006B, 3);
      wait_cyc(25);
      check(pin, 1'b1, "toggle not off");
      hit(16'h0064, 1);
      hit(16'h006B, 3);
      wait_cyc(50);
      check(calibrating, 1'b1, "toggle timeout not short");
      fe.burst(16'h0064);
      wait_cyc(25);
      check(pin, 1'b0, "toggle changed by recal");
      $display("t_toggle done");
    end
  endtask
  task t_drift;
    begin
      // four samples above the reference must not lift it by a single count
      start(1'b1, 1'b1, 1'b1, 16'h0064);
      hit(16'h0068, 4);
      hit(16'h006B, 3);
      check(detect_active, 1'b1, "reference rose too fast");
      start(1'b1, 1'b1, 1'b1, 16'h0064);
      hit(16'h005A, 4);
      hit(16'h0069, 3);
      check(detect_active, 1'b1, "reference did not follow down");
      $display("t_drift done");
    end
  endtask
  task test_done;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    t_integ;
    t_gain_low;
    t_timeout(1'b1, 1'b1, 40);
    t_timeout(1'b1, 1'b0, 80);
    t_timeout(1'b0, 1'b1, 0);
    t_toggle;
    t_drift;
    test_done;
  end
  // the run needs under a thousand cycles; ten thousand means a hang
  initial begin
    #100000;
    bad_count = bad_count + 1;
    test_done;
  end
endmodule // tb_top
